// ==== pdc_pkg.sv ====
// Package for the descriptor-driven peripheral DMA channel.
// Assumes a single clock domain and a plain register port from software.
package pdc_pkg;

  // Channel count and register offsets (byte addresses, word aligned).
  localparam int NUM_CH = 2;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CH_BASE = 8'h10;
  localparam logic [7:0] OFF_CH_STRIDE = 8'h10;
  localparam logic [3:0] OFF_CH_CTL = 4'h0;
  localparam logic [3:0] OFF_CH_PTR = 4'h4;
  localparam logic [3:0] OFF_CH_IDX = 4'h8;
  localparam logic [3:0] OFF_CH_SWTRIG = 4'hC;

  // Field positions.
  localparam int CTRL_ENABLE_BIT = 31;
  localparam int CH_ENABLE_BIT = 31;
  localparam int CH_PREEMPT_BIT = 11;
  localparam int CH_CHANNEL_PRIORITY_LSB = 8;
  localparam int IDX_OUTER_LSB = 16;

  // Descriptor control word field positions.
  localparam int D_WAIT_BIT = 0;
  localparam int D_INTR_LSB = 2;
  localparam int D_TOUT_LSB = 4;
  localparam int D_TIN_LSB = 6;
  localparam int D_SELFDIS_BIT = 8;
  localparam int D_SRCW_BIT = 9;
  localparam int D_DSTW_BIT = 10;
  localparam int D_ESIZE_LSB = 12;
  localparam int D_KIND_LSB = 16;

  // Descriptor word offsets.
  localparam logic [31:0] DSC_SRC = 32'h0000_0004;
  localparam logic [31:0] DSC_DST = 32'h0000_0008;
  localparam logic [31:0] DSC_XCTL = 32'h0000_000C;
  localparam logic [31:0] DSC_NEXT = 32'h0000_0010;

  // Codes.
  localparam logic [1:0] SCOPE_ELEM = 2'h0;
  localparam logic [1:0] SCOPE_INNER = 2'h1;
  localparam logic [1:0] SCOPE_DESC = 2'h2;
  localparam logic [1:0] SCOPE_LIST = 2'h3;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] KIND_1D = 2'h1;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pdc_reg_req_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
    logic wr;
    logic rd;
  } pdc_bus_req_type;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_D0 = 8'b0000_0010,
    ST_D1 = 8'b0000_0100,
    ST_D2 = 8'b0000_1000,
    ST_D3 = 8'b0001_0000,
    ST_D4 = 8'b0010_0000,
    ST_RD = 8'b0100_0000,
    ST_WR = 8'b1000_0000
  } pdc_state_type;

endpackage : pdc_pkg

// ==== pdc_channel.sv ====
// Descriptor-driven peripheral DMA engine with NUM_CH channels sharing one engine.
// Assumes a bus slave that answers every access with bus_ack after any delay,
// and read data valid in the acknowledge cycle.
// Outer loop indices are stored for software but do not drive any address.
//
// Summary of operation
// - Fetch descriptor at current pointer first.
// - Read source element, then write destination.
// - Advance addresses by step times size.
// - Source width setting 0 follows element width.
// - Self-disable clears channel enable at end.
// - Interrupt timing 0: interrupt per element.
// - Interrupt timing 1: interrupt per inner loop.
// - Output trigger timing 0: pulse per element.
// - Input scope 2: one trigger, whole descriptor.
// - No wait for trigger release when 0.
// - Next trigger fetches next-descriptor link.
// - Circular descriptor lists run indefinitely.
// - Software-writable current descriptor pointer per channel.
// - Non-preemptable channel keeps the engine.
// - Software priority field arbitrates pending channels.
// - Software-writable inner and outer index counters.
// - Controller enable bit31 gates every channel start from idle; a running channel is not stopped by it.
// - Per-channel enable bit, one enables.
// - Inner count field holds elements minus one.
// - Input scopes: element, inner, descriptor, list.
// - Output and interrupt timings: same four scopes.
`timescale 1ns/1ps
module pdc_channel
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  output logic [1:0] bus_size,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic [NUM_CH-1:0] trigger_in,
  output logic [NUM_CH-1:0] output_trigger,
  output logic [NUM_CH-1:0] channel_irq
);

  typedef struct packed {
    logic [31:0] rdata;
    logic controller_enable;
    logic [NUM_CH-1:0] channel_enable;
    logic [NUM_CH-1:0] preemptable;
    logic [NUM_CH-1:0][1:0] channel_priority;
    logic [NUM_CH-1:0][31:0] current_descriptor_pointer;
    logic [NUM_CH-1:0][15:0] inner_index;
    logic [NUM_CH-1:0][15:0] outer_index;
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] trig_prev;
    pdc_state_type state;
    logic [$clog2(NUM_CH)-1:0] chan;
    logic [31:0] dctl;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] xctl;
    logic [31:0] data;
    pdc_bus_req_type bus;
    logic [NUM_CH-1:0] otrig;
    logic [NUM_CH-1:0] irq;
  } pdc_core_type;

  pdc_core_type core_reg;
  pdc_core_type core_next;

  // Step scaled by bytes per element for a size code; used for address steps only, not access width.
  function automatic logic [31:0] pdc_scale(input logic [31:0] step, input logic [1:0] size);
    pdc_scale = step << size;
  endfunction : pdc_scale

  // Channel number decoded from a register address; callers take the register within it from the low nibble.
  // Addresses below the channel base are excluded by the callers.
  function automatic logic [3:0] pdc_ch_of(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - OFF_CH_BASE;
    pdc_ch_of = rel[7:4];
  endfunction : pdc_ch_of

  // Decoded fields of the active descriptor; meaningful only while a channel owns the engine.
  logic [1:0] esize;
  logic [1:0] src_w;
  logic [1:0] dst_w;
  logic [15:0] xcount;
  logic inner_done;
  logic desc_done;
  logic [1:0] tin;

  always_comb begin
    esize = core_reg.dctl[D_ESIZE_LSB +: 2];
    src_w = core_reg.dctl[D_SRCW_BIT] ? SIZE_WORD : esize;
    dst_w = core_reg.dctl[D_DSTW_BIT] ? SIZE_WORD : esize;
    xcount = core_reg.xctl[31:16];
    tin = core_reg.dctl[D_TIN_LSB +: 2];
    inner_done = core_reg.inner_index[core_reg.chan] == xcount;
    // One-dimensional kind ends with inner loop; other kinds treated alike.
    desc_done = inner_done;
  end

  // Next-state logic for registers, arbitration and the transfer sequencer.
  always_comb begin
    logic [3:0] rc;
    logic found;
    logic [1:0] best;
    logic [$clog2(NUM_CH)-1:0] pick;
    logic [1:0] itim;
    logic [1:0] otim;
    logic fire_i;
    logic fire_o;
    logic stop;
    logic [31:0] nxt;
    logic [NUM_CH-1:0] set_p;
    rc = 4'h0;
    found = 1'b0;
    best = 2'h0;
    pick = '0;
    itim = 2'h0;
    otim = 2'h0;
    fire_i = 1'b0;
    fire_o = 1'b0;
    stop = 1'b0;
    nxt = RST_ZERO;
    set_p = '0;
    core_next = core_reg;
    core_next.otrig = '0;
    core_next.irq = '0;
    core_next.rdata = RST_ZERO;
    core_next.trig_prev = trigger_in;

    // Rising trigger edges mark a channel pending; merged after the sequencer below.
    for (int i = 0; i < NUM_CH; i++) begin
      if (trigger_in[i] && !core_reg.trig_prev[i]) begin
        set_p[i] = 1'b1;
      end
    end

    // Register writes from software.
    rc = pdc_ch_of(reg_addr);
    if (reg_wr) begin
      if (reg_addr == OFF_CTRL) begin
        core_next.controller_enable = reg_wdata[CTRL_ENABLE_BIT];
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr >= OFF_CH_BASE && rc == 4'(i)) begin
          unique case (reg_addr[3:0])
            OFF_CH_CTL: begin
              core_next.channel_enable[i] = reg_wdata[CH_ENABLE_BIT];
              core_next.preemptable[i] = reg_wdata[CH_PREEMPT_BIT];
              core_next.channel_priority[i] = reg_wdata[CH_CHANNEL_PRIORITY_LSB +: 2];
            end
            OFF_CH_PTR: core_next.current_descriptor_pointer[i] = reg_wdata;
            OFF_CH_IDX: begin
              core_next.inner_index[i] = reg_wdata[15:0];
              core_next.outer_index[i] = reg_wdata[IDX_OUTER_LSB +: 16];
            end
            OFF_CH_SWTRIG: set_p[i] = reg_wdata[0];
            default: ;
          endcase
        end
      end
    end

    // Register reads: data stands in the following cycle.
    if (reg_rd) begin
      if (reg_addr == OFF_CTRL) begin
        core_next.rdata[CTRL_ENABLE_BIT] = core_reg.controller_enable;
      end else if (reg_addr == OFF_STATUS) begin
        core_next.rdata[7:0] = core_reg.state;
        core_next.rdata[8 +: NUM_CH] = core_reg.pending;
        core_next.rdata[16 +: $clog2(NUM_CH)] = core_reg.chan;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_addr >= OFF_CH_BASE && rc == 4'(i)) begin
          unique case (reg_addr[3:0])
            OFF_CH_CTL: begin
              core_next.rdata[CH_ENABLE_BIT] = core_reg.channel_enable[i];
              core_next.rdata[CH_PREEMPT_BIT] = core_reg.preemptable[i];
              core_next.rdata[CH_CHANNEL_PRIORITY_LSB +: 2] = core_reg.channel_priority[i];
            end
            OFF_CH_PTR: core_next.rdata = core_reg.current_descriptor_pointer[i];
            OFF_CH_IDX: core_next.rdata = {core_reg.outer_index[i], core_reg.inner_index[i]};
            default: ;
          endcase
        end
      end
    end

    // Lowest priority value wins among enabled pending channels.
    for (int i = 0; i < NUM_CH; i++) begin
      if (core_reg.pending[i] && core_reg.channel_enable[i]
          && (!found || core_reg.channel_priority[i] < best)) begin
        found = 1'b1;
        best = core_reg.channel_priority[i];
        pick = i[$clog2(NUM_CH)-1:0];
      end
    end

    // Timing fields come from the latched descriptor, so rewriting it in memory
    // mid-transfer has no effect until the next fetch.
    itim = core_reg.dctl[D_INTR_LSB +: 2];
    otim = core_reg.dctl[D_TOUT_LSB +: 2];
    nxt = core_reg.data;

    unique case (core_reg.state)
      ST_IDLE: begin
        if (core_reg.controller_enable && found) begin
          core_next.chan = pick;
          core_next.pending[pick] = 1'b0;
          core_next.bus = '{core_reg.current_descriptor_pointer[pick], RST_ZERO,
                            SIZE_WORD, 1'b0, 1'b1};
          core_next.state = ST_D0;
        end
      end
      ST_D0, ST_D1, ST_D2, ST_D3: begin
        if (bus_ack) begin
          core_next.bus.rd = 1'b1;
          unique case (core_reg.state)
            ST_D0: begin
              core_next.dctl = bus_rdata;
              core_next.bus.addr = core_reg.current_descriptor_pointer[core_reg.chan] + DSC_SRC;
              core_next.state = ST_D1;
            end
            ST_D1: begin
              core_next.src = bus_rdata;
              core_next.bus.addr = core_reg.current_descriptor_pointer[core_reg.chan] + DSC_DST;
              core_next.state = ST_D2;
            end
            ST_D2: begin
              core_next.dst = bus_rdata;
              core_next.bus.addr = core_reg.current_descriptor_pointer[core_reg.chan] + DSC_XCTL;
              core_next.state = ST_D3;
            end
            default: begin
              core_next.xctl = bus_rdata;
              core_next.bus.addr = core_reg.current_descriptor_pointer[core_reg.chan] + DSC_NEXT;
              core_next.state = ST_D4;
            end
          endcase
        end
      end
      ST_D4: begin
        if (bus_ack) begin
          core_next.data = bus_rdata;
          // Resume from the element the index counter points at.
          core_next.src = core_reg.src + pdc_scale(32'(core_reg.inner_index[core_reg.chan])
                          * 32'(core_reg.xctl[7:0]), esize);
          core_next.dst = core_reg.dst + pdc_scale(32'(core_reg.inner_index[core_reg.chan])
                          * 32'(core_reg.xctl[15:8]), esize);
          core_next.bus = '{core_next.src, RST_ZERO, src_w, 1'b0, 1'b1};
          core_next.state = ST_RD;
        end
      end
      ST_RD: begin
        if (bus_ack) begin
          // Then write it to the destination.
          core_next.bus = '{core_reg.dst, bus_rdata, dst_w, 1'b1, 1'b0};
          core_next.state = ST_WR;
        end
      end
      ST_WR: begin
        if (bus_ack) begin
          // Scaled inner steps after each element.
          core_next.src = core_reg.src + pdc_scale(32'(core_reg.xctl[7:0]), esize);
          core_next.dst = core_reg.dst + pdc_scale(32'(core_reg.xctl[15:8]), esize);
          core_next.inner_index[core_reg.chan] = core_reg.inner_index[core_reg.chan] + 16'h1;
          fire_i = itim == SCOPE_ELEM;
          fire_o = otim == SCOPE_ELEM;
          // Element scope stops after one element.
          stop = tin == SCOPE_ELEM;
          if (desc_done) begin
            core_next.inner_index[core_reg.chan] = 16'h0;
            fire_i = fire_i | (itim == SCOPE_INNER) | (itim == SCOPE_DESC);
            fire_o = fire_o | (otim == SCOPE_INNER) | (otim == SCOPE_DESC);
            // Follow the link; a circular list keeps alternating.
            core_next.current_descriptor_pointer[core_reg.chan] = nxt;
            // A zero link ends the chain.
            if (nxt == RST_ZERO) begin
              fire_i = fire_i | (itim == SCOPE_LIST);
              fire_o = fire_o | (otim == SCOPE_LIST);
              core_next.channel_enable[core_reg.chan] = 1'b0;
            end
            if (core_reg.dctl[D_SELFDIS_BIT]) begin
              core_next.channel_enable[core_reg.chan] = 1'b0;
            end
            // Scopes 0 to 2 end here; scope 3 runs the list.
            stop = (tin != SCOPE_LIST) || (nxt == RST_ZERO);
          end
          core_next.irq[core_reg.chan] = fire_i;
          core_next.otrig[core_reg.chan] = fire_o;
          // Finish without waiting for trigger release.
          if (stop || core_reg.dctl[D_WAIT_BIT] && trigger_in[core_reg.chan]) begin
            core_next.state = ST_IDLE;
          end else if (desc_done) begin
            core_next.bus = '{nxt, RST_ZERO, SIZE_WORD, 1'b0, 1'b1};
            core_next.state = ST_D0;
          // A preemptable channel yields to a better pending one.
          end else if (core_reg.preemptable[core_reg.chan] && found
                       && best < core_reg.channel_priority[core_reg.chan]) begin
            core_next.pending[core_reg.chan] = 1'b1;
            core_next.state = ST_IDLE;
          end else if (tin == SCOPE_INNER && inner_done) begin
            core_next.state = ST_IDLE;
          end else begin
            core_next.bus = '{core_next.src, RST_ZERO, src_w, 1'b0, 1'b1};
            core_next.state = ST_RD;
          end
        end
      end
      default: core_next.state = ST_IDLE;
    endcase

    // New trigger events are merged last so that a trigger landing in the
    // acceptance cycle stays pending instead of being lost to the clear.
    core_next.pending = core_next.pending | set_p;

    // A request stands one cycle past the ack only if reissued above.
    if (bus_ack && core_next.state == ST_IDLE) begin
      core_next.bus.rd = 1'b0;
      core_next.bus.wr = 1'b0;
    end
  end

  // Single state register. Reset clears every field except state (loaded with ST_IDLE) to zero, which is also the
  // idle level of the trigger inputs, so no false edge follows reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      core_reg <= '0;
      core_reg.state <= ST_IDLE;
    end else begin
      core_reg <= core_next;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata = core_reg.rdata;
  assign bus_addr = core_reg.bus.addr;
  assign bus_wdata = core_reg.bus.wdata;
  assign bus_size = core_reg.bus.size;
  assign bus_wr = core_reg.bus.wr;
  assign bus_rd = core_reg.bus.rd;
  assign output_trigger = core_reg.otrig;
  assign channel_irq = core_reg.irq;

endmodule : pdc_channel

// ==== pdc_checker.sv ====
// Port checker for the DMA channel engine.
// Assumes it is bound onto pdc_channel and sees only its ports.
`timescale 1ns/1ps
module pdc_checker
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [1:0] bus_size,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic [NUM_CH-1:0] trigger_in,
  input wire logic [NUM_CH-1:0] output_trigger,
  input wire logic [NUM_CH-1:0] channel_irq
);
  logic [31:0] last_reg;
  logic [1:0] last_size_reg;
  logic ctrl_on_reg;

  // The ports do not show the last value read or the controller enable, so both are tracked.
  always_ff @(posedge clock) begin
    if (reset) begin
      last_reg <= RST_ZERO;
      last_size_reg <= 2'h0;
      ctrl_on_reg <= 1'b0;
    end else begin
      if (bus_rd && bus_ack) begin
        last_reg <= bus_rdata;
        last_size_reg <= bus_size;
      end
      if (reg_wr && reg_addr == OFF_CTRL) begin
        ctrl_on_reg <= reg_wdata[CTRL_ENABLE_BIT];
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  copy_data_a: assert property (
    bus_wr && bus_size == SIZE_WORD && last_size_reg == SIZE_WORD |-> bus_wdata == last_reg)
    else $error("write data differs from the value read");
  hold_request_a: assert property (
    (bus_rd || bus_wr) && !bus_ack |=> $stable({bus_addr, bus_size, bus_rd, bus_wr, bus_wdata}))
    else $error("bus request changed before acknowledge");
  one_direction_a: assert property (!(bus_rd && bus_wr))
    else $error("read and write strobes together");
  read_then_next_a: assert property (bus_rd && bus_ack |-> ##[1:2] (bus_rd || bus_wr))
    else $error("no access follows a completed read");
  irq_after_write_a: assert property (channel_irq != 0 |-> $past(bus_wr && bus_ack))
    else $error("interrupt without a completed write");
  trig_after_write_a: assert property (output_trigger != 0 |-> $past(bus_wr && bus_ack))
    else $error("output trigger without a completed write");
  pulse_short_a: assert property (
    (channel_irq | output_trigger) != 0 |=> (channel_irq | output_trigger) == 0)
    else $error("event pulse longer than one cycle");
  gate_off_a: assert property (!ctrl_on_reg && !bus_rd && !bus_wr |=> !bus_rd)
    else $error("bus read started while controller disabled");
  size_legal_a: assert property ((bus_rd || bus_wr) |-> bus_size <= SIZE_WORD)
    else $error("illegal bus access size");
  rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == RST_ZERO)
    else $error("register read data outside its cycle");

  cover property (bus_rd && bus_ack && bus_size == 2'h0);
  cover property (channel_irq[1]);
  cover property (output_trigger[0]);
endmodule : pdc_checker

bind pdc_channel pdc_checker u_chk (.clock(clock), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .trigger_in(trigger_in),
  .output_trigger(output_trigger), .channel_irq(channel_irq));

// ==== pdc_bus_model.sv ====
// System bus memory model answering the engine's master port.
// Assumes the engine holds each request until bus_ack.
`timescale 1ns/1ps
module pdc_bus_model
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [1:0] bus_size,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [67:0] acc_q [$];
  logic [1:0] wait_reg;
  logic [1:0] delay_reg;
  logic [31:0] value;

  // Wait states cycle 0, 1, 2 so prompt and slow answers both occur; idle data keeps toggling.
  always @(posedge clock) begin
    if (reset) begin
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0000_0000;
      wait_reg <= 2'h0;
      delay_reg <= 2'h0;
    end else if (bus_ack || !(bus_rd || bus_wr)) begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      wait_reg <= 2'h0;
    end else if (wait_reg != delay_reg) begin
      wait_reg <= wait_reg + 2'h1;
      bus_rdata <= ~bus_rdata;
    end else begin
      value = mem.exists(bus_addr) ? mem[bus_addr] : ~bus_addr;
      if (bus_wr) begin
        mem[bus_addr] = bus_wdata;
        value = bus_wdata;
      end
      bus_ack <= 1'b1;
      bus_rdata <= bus_wr ? ~bus_rdata : value;
      delay_reg <= (delay_reg == 2'h2) ? 2'h0 : delay_reg + 2'h1;
      acc_q.push_back({1'b1, bus_wr, bus_size, bus_addr, value});
    end
  end
endmodule : pdc_bus_model

// ==== testbench.sv ====
// Self-checking bench for the DMA channel engine and its bus memory.
// Assumes the register map and descriptor layout of the package.
`timescale 1ns/1ps
module testbench
  import pdc_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [NUM_CH-1:0] trigger_in = '0;
  logic [31:0] reg_rdata, bus_addr, bus_wdata, bus_rdata, rd_val, rd_exp;
  logic [1:0] bus_size;
  logic bus_wr, bus_rd, bus_ack;
  logic [NUM_CH-1:0] output_trigger, channel_irq;
  int err_count = 0;
  int check_count = 0;
  int irq_cnt [NUM_CH] = '{0, 0};
  int out_cnt [NUM_CH] = '{0, 0};
  int seed = 32'h0000_0F87;
  logic [67:0] exp_q [$];
  logic [31:0] src_val [logic [31:0]];

  pdc_channel u_dut (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_size(bus_size), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .trigger_in(trigger_in),
    .output_trigger(output_trigger), .channel_irq(channel_irq));
  pdc_bus_model u_mem (.clock(clock), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_size(bus_size), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata));

  // Clock and event pulse counters.
  always #4 clock = ~clock;
  always @(posedge clock) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (channel_irq[i] === 1'b1) irq_cnt[i]++;
      if (output_trigger[i] === 1'b1) out_cnt[i]++;
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [67:0] exp, input logic [67:0] got);
    check_count++;
    if (exp !== got) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  function automatic logic [7:0] ch_reg(input int n, input logic [3:0] off);
    return OFF_CH_BASE + OFF_CH_STRIDE * 8'(n) + 8'(off);
  endfunction : ch_reg

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic trig(input int ch);
    @(posedge clock);
    trigger_in[ch] <= 1'b1;
    repeat (2) @(posedge clock);
    trigger_in[ch] <= 1'b0;
  endtask : trig

  // Loads a descriptor and queues the fetch, then one read and one write per element.
  task automatic exp_desc(input logic [31:0] p, c, s, d, x, n);
    logic [31:0] w [5];
    logic [31:0] a;
    int es;
    logic [1:0] ss, ds;
    w = '{c, s, d, x, n};
    es = c[D_ESIZE_LSB +: 2];
    ss = c[D_SRCW_BIT] ? SIZE_WORD : 2'(es);
    ds = c[D_DSTW_BIT] ? SIZE_WORD : 2'(es);
    for (int k = 0; k < 5; k++) begin
      u_mem.mem[p + 32'(4 * k)] = w[k];
      exp_q.push_back({1'b1, 1'b0, SIZE_WORD, p + 32'(4 * k), w[k]});
    end
    for (int i = 0; i <= int'(x[31:16]); i++) begin
      a = s + 32'((i * x[7:0]) << es);
      w[0] = src_val.exists(a) ? src_val[a] : 32'h0000_0000;
      exp_q.push_back({es == 2, 1'b0, ss, a, w[0]});
      exp_q.push_back({es == 2, 1'b1, ds, d + 32'((i * x[15:8]) << es), w[0]});
    end
  endtask : exp_desc

  // Waits under a bound for the queued accesses, then compares them in order.
  task automatic wait_done;
    logic [67:0] e, got;
    for (int n = 0; n < 4000 && u_mem.acc_q.size() < exp_q.size(); n++) @(posedge clock);
    repeat (4) @(posedge clock);
    if (u_mem.acc_q.size() != exp_q.size()) begin
      err_count++;
      $display("[ERR] accesses expected %0d seen %0d", exp_q.size(), u_mem.acc_q.size());
      final_report();
    end else begin
      while (exp_q.size() > 0) begin
        e = exp_q.pop_front();
        got = u_mem.acc_q.pop_front();
        if (!e[67]) got[31:0] = e[31:0];
        got[67] = e[67];
        check("bus access", e, got);
      end
    end
  endtask : wait_done

  // Hang guard.
  initial begin
    #720000;
    err_count++;
    $display("[ERR] run expected finish seen timeout");
    final_report();
  end

  // Main sequence: registers, byte transfer with self-disable, then a circular list.
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    reg_read(OFF_CTRL, rd_val);
    check("ctrl reset", 0, rd_val);
    rd_exp = $random(seed);
    reg_write(ch_reg(0, OFF_CH_IDX), rd_exp);
    reg_read(ch_reg(0, OFF_CH_IDX), rd_val);
    check("index", rd_exp, rd_val);
    reg_write(ch_reg(0, OFF_CH_IDX), 32'h0000_0000);
    reg_write(8'hF0, rd_val);
    reg_read(8'hF0, rd_val);
    check("unmapped", 0, rd_val);
    reg_write(ch_reg(0, OFF_CH_PTR), 32'h0000_0100);
    reg_read(ch_reg(0, OFF_CH_PTR), rd_val);
    check("pointer", 32'h0000_0100, rd_val);
    $display("test registers done");
    reg_write(OFF_CTRL, 32'h0000_0000);
    reg_write(ch_reg(0, OFF_CH_CTL), 32'h8000_0100);
    exp_desc(32'h100, 32'h0001_0580, 32'h400, 32'h500, 32'h0003_0001, 32'h0);
    trig(0);
    repeat (40) @(posedge clock);
    check("idle while off", 0, u_mem.acc_q.size());
    reg_write(OFF_CTRL, 32'h8000_0000);
    wait_done();
    check("irq per element", 4, irq_cnt[0]);
    check("out per element", 4, out_cnt[0]);
    reg_read(ch_reg(0, OFF_CH_CTL), rd_val);
    check("self disable", 0, rd_val[CH_ENABLE_BIT]);
    $display("test single descriptor done");
    reg_write(ch_reg(1, OFF_CH_PTR), 32'h0000_0200);
    reg_write(ch_reg(1, OFF_CH_CTL), 32'h8000_0000);
    for (int i = 0; i < 3; i++) begin
      src_val[32'h8000 + 32'(i * 128)] = $random(seed);
      u_mem.mem[32'h8000 + 32'(i * 128)] = src_val[32'h8000 + 32'(i * 128)];
    end
    for (int k = 0; k < 3; k++) begin
      exp_desc(k[0] ? 32'h240 : 32'h200, 32'h0001_2084, 32'h8000, k[0] ? 32'h2000 : 32'h1000,
        32'h0002_0120, k[0] ? 32'h200 : 32'h240);
      if (k == 1) reg_write(ch_reg(1, OFF_CH_SWTRIG), 32'h0000_0001);
      else trig(1);
      wait_done();
    end
    check("irq per inner loop", 3, irq_cnt[1]);
    check("out per element", 9, out_cnt[1]);
    reg_read(ch_reg(1, OFF_CH_CTL), rd_val);
    check("stays enabled", 1, rd_val[CH_ENABLE_BIT]);
    $display("test circular list done");
    final_report();
  end
endmodule : testbench
